// ### hdl/autoclass_cfg.svh
// Constants of the autoclass power-limit block: command offsets, field positions,
// reset values, margin bands, class ceilings and timing counts.
// Assumes a 125 MHz system clock and 0.5 W per power count.
`ifndef AUTOCLASS_CFG_SVH
`define AUTOCLASS_CFG_SVH

`define ASSIGNED_CLASS_ADDR0  8'h4c
`define AUTOCLASS_CTRL_ADDR   8'h50
`define AUTOCLASS_POWER_ADDR0 8'h51
`define AUTOCLASS_CTRL_RESET  8'h00
`define MEAS_REQ_LSB          4
`define AUTO_ADJ_LSB          0
`define READ_DEFAULT          8'h00

// Margin band edges in 0.5 W counts; a value on an edge takes the upper band.
`define BAND1_TOP 9'h025
`define BAND2_TOP 9'h033
`define BAND3_TOP 9'h049
`define BAND4_TOP 9'h05a
`define BAND5_TOP 9'h067
`define BAND6_TOP 9'h074
`define BAND7_TOP 9'h07e
`define BAND8_TOP 9'h088
`define BAND9_TOP 9'h092
`define MARGIN_B1  9'h001
`define MARGIN_B2  9'h002
`define MARGIN_B3  9'h004
`define MARGIN_B4  9'h006
`define MARGIN_B5  9'h008
`define MARGIN_B6  9'h00a
`define MARGIN_B7  9'h00c
`define MARGIN_B8  9'h00e
`define MARGIN_B9  9'h010
`define MARGIN_B10 9'h012

// Upper end of each assigned class range in 0.5 W counts.
`define CEIL_CLS1  9'h008
`define CEIL_CLS2  9'h00e
`define CEIL_CLS3  9'h01e
`define CEIL_CLS4  9'h03c
`define CEIL_CLS5S 9'h05a
`define CEIL_CLS6S 9'h078
`define CEIL_CLS7S 9'h096
`define CEIL_CLS8S 9'h0b4
`define CEIL_CLS5D 9'h05a

`define CLK_KHZ          125000
`define MEAS_START_MS    10
`define MEAS_CLEAR_MS    1
`define ADJUST_MS        5
`define CLASS_REPORT_MS  5
`define MEAS_START_CYC   (`MEAS_START_MS * `CLK_KHZ)
`define MEAS_CLEAR_CYC   (`MEAS_CLEAR_MS * `CLK_KHZ)
`define ADJUST_CYC       (`ADJUST_MS * `CLK_KHZ)
`define CLASS_REPORT_CYC (`CLASS_REPORT_MS * `CLK_KHZ)

`endif

// ### hdl/autoclass_pkg.sv
// Types of the autoclass power-limit block: class codes, channel vectors, states.
// Assumes four channels grouped in two ports of two channels.
package autoclass_pkg;

  typedef enum logic [3:0] {
    CLS_UNKNOWN = 4'h0,
    CLS_1       = 4'h1,
    CLS_2       = 4'h2,
    CLS_3       = 4'h3,
    CLS_4       = 4'h4,
    CLS_0       = 4'h6,
    CLS_5S      = 4'h8,
    CLS_6S      = 4'h9,
    CLS_7S      = 4'ha,
    CLS_8S      = 4'hb,
    CLS_5D      = 4'hd
  } class_code_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MEAS = 3'b010,
    ST_ADJ  = 3'b100
  } meas_state_t;

  typedef logic [3:0]       chan_t;
  typedef logic [1:0]       port_t;
  typedef logic [3:0][3:0]  code_arr_t;
  typedef logic [3:0][6:0]  power_arr_t;
  typedef logic [3:0][8:0]  pair_lim_t;
  typedef logic [1:0][8:0]  four_lim_t;

  // Any reserved code maps to unknown.
  function automatic logic [3:0] legal_prev_class(input logic [3:0] code);
    logic [3:0] res;
    res = 4'h0;
    case (code)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'h9, 4'ha, 4'hb, 4'hd: res = code;
      default: res = 4'h0;
    endcase
    return res;
  endfunction

endpackage

// ### hdl/limit_calc_if.sv
// Carrier between the top and its margin and limit leaves.
// Assumes the user side drives power and class and reads limit and fits.
`timescale 1ns/10ps
`default_nettype none
interface limit_calc_if #(parameter int W = 9);
  logic [W-1:0] power;
  logic [W-1:0] margin;
  logic [3:0]   classCode;
  logic [W-1:0] limit;
  logic         fits;
  modport table_side (input power, output margin);
  modport judge_side (input power, input margin, input classCode, output limit, output fits);
  modport user       (output power, output classCode, input limit, input fits);
endinterface
`default_nettype wire

// ### hdl/margin_table.sv
// Margin lookup: measured power in 0.5 W counts to the required surplus.
// Assumes power is zero-extended into the interface width.
`timescale 1ns/10ps
`default_nettype none
`include "autoclass_cfg.svh"
module margin_table (
  limit_calc_if.table_side calc
);
  // RULE15 RULE24 banded margin
  always_comb begin
    if (calc.power < `BAND1_TOP) calc.margin = `MARGIN_B1;
    else if (calc.power < `BAND2_TOP) calc.margin = `MARGIN_B2;
    else if (calc.power < `BAND3_TOP) calc.margin = `MARGIN_B3;
    else if (calc.power < `BAND4_TOP) calc.margin = `MARGIN_B4;
    else if (calc.power < `BAND5_TOP) calc.margin = `MARGIN_B5;
    else if (calc.power < `BAND6_TOP) calc.margin = `MARGIN_B6;
    else if (calc.power < `BAND7_TOP) calc.margin = `MARGIN_B7;
    else if (calc.power < `BAND8_TOP) calc.margin = `MARGIN_B8;
    else if (calc.power < `BAND9_TOP) calc.margin = `MARGIN_B9;
    else calc.margin = `MARGIN_B10;
  end
endmodule // margin_table
`default_nettype wire

// ### hdl/limit_judge.sv
// Limit judge: power plus margin, and whether it stays inside the class range.
// Assumes the class code is an assigned class; unknown never fits.
`timescale 1ns/10ps
`default_nettype none
`include "autoclass_cfg.svh"
module limit_judge (
  limit_calc_if.judge_side calc
);
  logic [8:0] ceiling;

  // RULE21 class range check
  always_comb begin
    ceiling = 9'h000;
    case (calc.classCode)
      4'h1: ceiling = `CEIL_CLS1;
      4'h2: ceiling = `CEIL_CLS2;
      4'h3: ceiling = `CEIL_CLS3;
      4'h4: ceiling = `CEIL_CLS4;
      4'h8: ceiling = `CEIL_CLS5S;
      4'h9: ceiling = `CEIL_CLS6S;
      4'ha: ceiling = `CEIL_CLS7S;
      4'hb: ceiling = `CEIL_CLS8S;
      4'hd: ceiling = `CEIL_CLS5D;
      default: ceiling = 9'h000;
    endcase
    calc.limit = calc.power + calc.margin;
    calc.fits  = (ceiling != 9'h000) && (calc.limit <= ceiling);
  end
endmodule // limit_judge
`default_nettype wire

// ### hdl/autoclass_power_limit_control.sv
// Classification reporting and autoclass power-limit control for four channels.
// Assumes the command port, channel status and measurement engine share sys_clk.
// Notes on behaviour
// RULE1 - Previous class codes follow the class table; reserved codes read as unknown.
// RULE2 - Assigned class is the level powered with, from the allocation setting.
// RULE3 - Single-signature four-pair: both channels share class; flag only measured channel.
// RULE4 - Dual-signature four-pair: each channel reports its own assigned class.
// RULE5 - A class 0 load is recorded with assigned class 3 when powered.
// RULE6 - Manual mode channels get no assigned class; host sets policing itself.
// RULE7 - One-finger 15.4 W turn-on in semi-auto stores the prior 3-finger class.
// RULE8 - Host trusts previous class only in semi-auto with detect and class on.
// RULE9 - Control register: requests in bits 7-4, auto-adjust in 3-0, RW, reset zero.
// RULE10 - A set measurement request starts the measurement within 10 ms.
// RULE11 - Request bit clears within 1 ms after the measured power is updated.
// RULE12 - Requests set before turn-on are ignored and cleared at turn-on.
// RULE13 - With auto-adjust on, limits update within 5 ms after the window ends.
// RULE14 - With auto-adjust off the host adjusts limits using the margin table.
// RULE15 - Margin steps from 0.5 W below 18.5 W up to 9 W above 73 W.
// RULE16 - Two-pair or dual-signature: each pair-set limit becomes its power plus margin.
// RULE17 - Single-signature four-pair limit is both powers summed plus margin.
// RULE18 - Single-signature results leave the pair-set limits unchanged.
// RULE19 - One auto-adjust bit of a single-signature port still updates four-pair limit.
// RULE20 - One request bit alone on a single-signature port completes no measurement.
// RULE21 - Limits stay unchanged when power plus margin exceeds the class range.
// RULE22 - Channel power registers are read-only 7-bit, bit 7 zero, reset zero.
// RULE23 - Measured power is the engine's peak average result at 0.5 W per count.
// RULE24 - Power in a gap or on a band edge takes the higher band margin.
`timescale 1ns/10ps
`default_nettype none
`include "autoclass_cfg.svh"
module autoclass_power_limit_control #(
  parameter int START_CYC = `MEAS_START_CYC,
  parameter int CLEAR_CYC = `MEAS_CLEAR_CYC
) (
  input  wire logic                     sys_clk,
  input  wire logic                     arst_n,
  input  wire logic [7:0]               regAddr,
  input  wire logic                     regWr,
  input  wire logic [7:0]               regWrData,
  input  wire logic                     regRd,
  output logic [7:0]                    regRdData,
  input  wire autoclass_pkg::chan_t     chOn,
  input  wire autoclass_pkg::chan_t     powerOnPulse,
  input  wire autoclass_pkg::chan_t     manualMode,
  input  wire autoclass_pkg::chan_t     semiAuto,
  input  wire autoclass_pkg::chan_t     detectEnable,
  input  wire autoclass_pkg::chan_t     classEnable,
  input  wire autoclass_pkg::chan_t     classZero,
  input  wire autoclass_pkg::chan_t     oneFinger,
  input  wire autoclass_pkg::code_arr_t allocClass,
  input  wire autoclass_pkg::code_arr_t prevClassIn,
  input  wire autoclass_pkg::port_t     fourPairPort,
  input  wire autoclass_pkg::port_t     singleSig,
  input  wire autoclass_pkg::chan_t     classDone,
  output autoclass_pkg::chan_t          classCompleteSet,
  output autoclass_pkg::chan_t          acStart,
  input  wire autoclass_pkg::chan_t     acWindowDone,
  input  wire autoclass_pkg::power_arr_t acPowerIn,
  input  wire autoclass_pkg::chan_t     pairLimitWr,
  input  wire autoclass_pkg::port_t     fourLimitWr,
  input  wire logic [8:0]               limitWrData,
  output autoclass_pkg::pair_lim_t      pairLimit,
  output autoclass_pkg::four_lim_t      fourLimit
);
  import autoclass_pkg::*;

  logic [7:0]  ctrl_r;
  logic [7:0]  ctrlNxt;
  code_arr_t   assigned_class_code_r;
  code_arr_t   previous_class_code_r;
  power_arr_t  power_r;
  pair_lim_t   pairLimit_r;
  four_lim_t   fourLimit_r;
  chan_t       acStart_r;
  chan_t       classComplete_r;
  chan_t       chOnPrev_r;
  chan_t       single4p;
  chan_t       startGo;
  chan_t       inAdj;
  chan_t       pairFits;
  pair_lim_t   pairCalcLimit;
  port_t       fourFits;
  four_lim_t   fourCalcLimit;
  meas_state_t st_r [4];
  logic [7:0]  rdData_r;
  logic        ctrlWr;

  assign ctrlWr           = regWr && (regAddr == `AUTOCLASS_CTRL_ADDR);
  assign regRdData        = rdData_r;
  assign acStart          = acStart_r;
  assign classCompleteSet = classComplete_r;
  assign pairLimit        = pairLimit_r;
  assign fourLimit        = fourLimit_r;

  // RULE9 RULE11 RULE12 control register
  always_comb begin
    ctrlNxt = ctrl_r;
    for (int c = 0; c < 4; c++) begin
      // A software write in the same cycle as a hardware clear wins.
      if (ctrlWr) begin
        ctrlNxt[`MEAS_REQ_LSB + c] = regWrData[`MEAS_REQ_LSB + c];
        ctrlNxt[`AUTO_ADJ_LSB + c] = regWrData[`AUTO_ADJ_LSB + c];
      end else if (inAdj[c] || powerOnPulse[c]) begin
        ctrlNxt[`MEAS_REQ_LSB + c] = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `AUTOCLASS_CTRL_RESET;
    end else begin
      ctrl_r <= ctrlNxt;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_r <= `READ_DEFAULT;
    end else if (regRd) begin
      // RULE22 read-only power view
      if (regAddr >= `AUTOCLASS_POWER_ADDR0 && regAddr < `AUTOCLASS_POWER_ADDR0 + 8'h04) begin
        rdData_r <= {1'b0, power_r[2'(regAddr - `AUTOCLASS_POWER_ADDR0)]};
      end else if (regAddr >= `ASSIGNED_CLASS_ADDR0 && regAddr < `AUTOCLASS_CTRL_ADDR) begin
        rdData_r <= {assigned_class_code_r[2'(regAddr - `ASSIGNED_CLASS_ADDR0)],
                     previous_class_code_r[2'(regAddr - `ASSIGNED_CLASS_ADDR0)]};
      end else if (regAddr == `AUTOCLASS_CTRL_ADDR) begin
        rdData_r <= ctrl_r;
      end else begin
        rdData_r <= `READ_DEFAULT;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      chOnPrev_r      <= 4'h0;
      classComplete_r <= 4'h0;
    end else begin
      chOnPrev_r      <= chOn;
      // RULE3 flag on measured channel
      classComplete_r <= classDone;
    end
  end

  for (genvar c = 0; c < 4; c++) begin : g_chan
    localparam int P = c / 2;
    localparam int Q = c ^ 1;
    limit_calc_if #(.W(9)) pairIf ();
    logic [20:0] waitCnt_r;
    logic [20:0] clrCnt_r;
    logic [3:0]  ownClass;
    logic [3:0]  mateClass;

    assign single4p[c]      = fourPairPort[P] && singleSig[P];
    assign inAdj[c]         = (st_r[c] == ST_ADJ);
    // RULE20 paired request needed
    assign startGo[c]       = (st_r[c] == ST_IDLE) && chOn[c] && !powerOnPulse[c]
                              && ctrl_r[`MEAS_REQ_LSB + c] && !acWindowDone[c]
                              && (!single4p[c] || ctrl_r[`MEAS_REQ_LSB + Q]);
    assign pairIf.power     = {2'b00, power_r[c]};
    assign pairIf.classCode = assigned_class_code_r[c];
    assign pairFits[c]      = pairIf.fits;
    assign pairCalcLimit[c] = pairIf.limit;

    margin_table u_margin (.calc(pairIf));
    limit_judge  u_judge  (.calc(pairIf));

    // RULE2 RULE5 RULE6 assigned class source
    always_comb begin
      ownClass  = manualMode[c] ? CLS_UNKNOWN : (classZero[c] ? CLS_3 : allocClass[c]);
      mateClass = manualMode[Q] ? CLS_UNKNOWN : (classZero[Q] ? CLS_3 : allocClass[Q]);
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        assigned_class_code_r[c] <= CLS_UNKNOWN;
        previous_class_code_r[c] <= CLS_UNKNOWN;
      end else if (chOnPrev_r[c] && !chOn[c]) begin
        assigned_class_code_r[c] <= CLS_UNKNOWN;
        previous_class_code_r[c] <= CLS_UNKNOWN;
      end else begin
        // RULE3 RULE4 class per signature type
        if (powerOnPulse[c]) begin
          assigned_class_code_r[c] <= ownClass;
        end else if (single4p[c] && powerOnPulse[Q]) begin
          assigned_class_code_r[c] <= mateClass;
        end
        // RULE1 RULE7 previous class capture
        if (powerOnPulse[c]) begin
          if (semiAuto[c] && detectEnable[c] && classEnable[c] && oneFinger[c]) begin
            previous_class_code_r[c] <= legal_prev_class(prevClassIn[c]);
          end else begin
            previous_class_code_r[c] <= CLS_UNKNOWN;
          end
        end
      end
    end

    // RULE10 RULE11 measurement sequence
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        st_r[c]      <= ST_IDLE;
        acStart_r[c] <= 1'b0;
      end else begin
        acStart_r[c] <= startGo[c];
        case (st_r[c])
          ST_IDLE: begin
            if (acWindowDone[c]) st_r[c] <= ST_ADJ;
            else if (startGo[c]) st_r[c] <= ST_MEAS;
          end
          ST_MEAS: begin
            if (acWindowDone[c]) st_r[c] <= ST_ADJ;
            else if (!chOn[c]) st_r[c] <= ST_IDLE;
          end
          ST_ADJ:  st_r[c] <= ST_IDLE;
          default: st_r[c] <= ST_IDLE;
        endcase
      end
    end

    // RULE23 store engine result
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        power_r[c] <= 7'h00;
      end else if (acWindowDone[c]) begin
        power_r[c] <= acPowerIn[c];
      end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        pairLimit_r[c] <= 9'h000;
      end else if (pairLimitWr[c]) begin
        pairLimit_r[c] <= limitWrData;
      // RULE13 RULE16 RULE18 RULE21 pair-set update
      end else if (inAdj[c] && ctrl_r[`AUTO_ADJ_LSB + c] && !single4p[c] && pairFits[c]) begin
        pairLimit_r[c] <= pairCalcLimit[c];
      end
    end

    // Helper counters only watch the deadlines; the logic itself acts within a cycle.
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        waitCnt_r <= 21'h000000;
        clrCnt_r  <= 21'h000000;
      end else begin
        // Counts cycles of a startable request that has not yet left idle.
        waitCnt_r <= (st_r[c] == ST_IDLE && chOn[c] && ctrl_r[`MEAS_REQ_LSB + c]
                      && (!single4p[c] || ctrl_r[`MEAS_REQ_LSB + Q]))
                     ? waitCnt_r + 21'h000001 : 21'h000000;
        // Counts cycles from a stored result until the request bit drops.
        clrCnt_r  <= acWindowDone[c] ? 21'h000001
                     : ((clrCnt_r != 21'h000000) && ctrl_r[`MEAS_REQ_LSB + c] && !ctrlWr)
                     ? clrCnt_r + 21'h000001 : 21'h000000;
      end
    end

    a_start_deadline: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE10
      waitCnt_r < 21'(START_CYC)) else $error("request not started in time");
    a_start_pulse: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE10
      startGo[c] |=> acStart_r[c] && st_r[c] == ST_MEAS) else $error("no start");
    a_req_self_clear: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE11
      acWindowDone[c] ##1 !ctrlWr |=> !ctrl_r[`MEAS_REQ_LSB + c]) else $error("req kept");
    a_clear_deadline: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE11
      clrCnt_r < 21'(CLEAR_CYC)) else $error("request not cleared in time");
    a_turnon_clear: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE12
      powerOnPulse[c] && !ctrlWr |=> !ctrl_r[`MEAS_REQ_LSB + c]) else $error("stale req");
    a_power_capture: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE23
      acWindowDone[c] |=> power_r[c] == $past(acPowerIn[c])) else $error("power lost");
    a_class_zero: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE5
      powerOnPulse[c] && !manualMode[c] && classZero[c] && chOn[c]
      |=> assigned_class_code_r[c] == CLS_3) else $error("class 0 not 3");
    a_manual_none: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE6
      powerOnPulse[c] && manualMode[c] && chOn[c] |=> assigned_class_code_r[c] == CLS_UNKNOWN)
      else $error("manual got class");
    a_single_mate: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE3
      powerOnPulse[c] && !powerOnPulse[Q] && single4p[c] && chOn[c] && chOn[Q]
      |=> assigned_class_code_r[Q] == assigned_class_code_r[c]) else $error("mate class");
    a_single_pair_kept: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE18
      inAdj[c] && single4p[c] && !pairLimitWr[c] |=> $stable(pairLimit_r[c]))
      else $error("pair limit moved");
    a_pair_update: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE16
      inAdj[c] && !single4p[c] && ctrl_r[`AUTO_ADJ_LSB + c] && pairFits[c] && !pairLimitWr[c]
      |=> pairLimit_r[c] == $past(pairCalcLimit[c])) else $error("pair not set");
    a_nofit_kept: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE21
      inAdj[c] && !pairFits[c] && !pairLimitWr[c] |=> $stable(pairLimit_r[c]))
      else $error("limit out of range");
    a_lone_request: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE20
      single4p[c] && !ctrl_r[`MEAS_REQ_LSB + Q] |=> !acStart_r[c]) else $error("lone start");
  end

  for (genvar p = 0; p < 2; p++) begin : g_port
    limit_calc_if #(.W(9)) fourIf ();
    logic adjAny;
    logic adjEnable;

    // RULE17 summed port power
    assign fourIf.power     = {2'b00, power_r[2*p]} + {2'b00, power_r[2*p+1]};
    assign fourIf.classCode = assigned_class_code_r[2*p];
    assign fourFits[p]      = fourIf.fits;
    assign fourCalcLimit[p] = fourIf.limit;
    assign adjAny           = inAdj[2*p] || inAdj[2*p+1];
    // RULE19 either auto-adjust bit suffices
    assign adjEnable        = ctrl_r[`AUTO_ADJ_LSB + 2*p] || ctrl_r[`AUTO_ADJ_LSB + 2*p+1];

    margin_table u_margin (.calc(fourIf));
    limit_judge  u_judge  (.calc(fourIf));

    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        fourLimit_r[p] <= 9'h000;
      end else if (fourLimitWr[p]) begin
        fourLimit_r[p] <= limitWrData;
      // RULE13 RULE17 RULE21 four-pair update
      end else if (adjAny && adjEnable && single4p[2*p] && fourFits[p]) begin
        fourLimit_r[p] <= fourCalcLimit[p];
      end
    end

    a_four_update: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE19
      adjAny && adjEnable && single4p[2*p] && fourFits[p] && !fourLimitWr[p]
      |=> fourLimit_r[p] == $past(fourCalcLimit[p])) else $error("four-pair not set");
  end

  a_power_bit7: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE22
    regRd && regAddr == `AUTOCLASS_POWER_ADDR0 |=> regRdData == {1'b0, $past(power_r[0])})
    else $error("power view wrong");
endmodule // autoclass_power_limit_control
`default_nettype wire

// ### bench/ac_engine_model.sv
// Far-side autoclass measurement engine model: answers each start pulse with a window-done pulse.
// Assumes start pulses last one cycle and that powerSet is held by the bench.
`timescale 1ns/10ps
`default_nettype none
module ac_engine_model #(
  parameter int LAT = 20
) (
  input  wire logic                      sys_clk,
  input  wire autoclass_pkg::chan_t      acStart,
  input  wire autoclass_pkg::power_arr_t powerSet,
  output autoclass_pkg::chan_t           acWindowDone,
  output autoclass_pkg::power_arr_t      acPowerIn
);
  import autoclass_pkg::*;
  int cnt [4] = '{0, 0, 0, 0};
  // peak power result
  // Outside the done pulse the bus carries the inverse, so a stale sample cannot pass.
  always @(posedge sys_clk) begin
    for (int c = 0; c < 4; c++) begin
      cnt[c] <= acStart[c] ? LAT : ((cnt[c] > 0) ? cnt[c] - 1 : 0);
      acWindowDone[c] <= (cnt[c] == 1);
      acPowerIn[c] <= (cnt[c] == 1) ? powerSet[c] : ~powerSet[c];
    end
  end
endmodule // ac_engine_model
`default_nettype wire

// ### bench/autoclass_power_limit_control_test.sv
// Self-checking bench of the autoclass power-limit block: registers, classes, measurements.
// Assumes ac_engine_model stands in for the measurement engine.
`timescale 1ns/10ps
`default_nettype none
module autoclass_power_limit_control_test;
  import autoclass_pkg::*;
  logic       sys_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic [7:0] rdv;
  logic       regWr = 1'b0;
  logic       regRd = 1'b0;
  logic [8:0] starts = 9'h000;
  chan_t      chOn = '0, powerOnPulse = '0, manualMode = '0, semiAuto = '0;
  chan_t      detectEnable = '0, classEnable = '0, classZero = '0, oneFinger = '0;
  chan_t      classDone = '0, pairLimitWr = '0, classCompleteSet, acStart, acWindowDone;
  code_arr_t  allocClass = '0, prevClassIn = '0;
  port_t      fourPairPort = '0, singleSig = '0, fourLimitWr = '0;
  logic [8:0] limitWrData = 9'h000;
  power_arr_t acPowerIn, powerSet = '0;
  pair_lim_t  pairLimit;
  four_lim_t  fourLimit;
  int         n_mismatch = 0;
  int         tests_run = 0;
  logic [6:0] pw [3] = '{7'h14, 7'h25, 7'h3a};
  logic [8:0] lim [3] = '{9'h015, 9'h027, 9'h027};

  always #4 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (|acStart) starts <= starts + 9'h001;

  autoclass_power_limit_control #(.START_CYC(64), .CLEAR_CYC(64)) dut (
    .sys_clk, .arst_n, .regAddr, .regWr, .regWrData, .regRd, .regRdData, .chOn,
    .powerOnPulse, .manualMode, .semiAuto, .detectEnable, .classEnable, .classZero,
    .oneFinger, .allocClass, .prevClassIn, .fourPairPort, .singleSig, .classDone,
    .classCompleteSet, .acStart, .acWindowDone, .acPowerIn, .pairLimitWr, .fourLimitWr,
    .limitWrData, .pairLimit, .fourLimit);
  ac_engine_model engine (.sys_clk, .acStart, .powerSet, .acWindowDone, .acPowerIn);

  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regWrData = d;
    regWr = 1'b1;
    @(negedge sys_clk);
    regWr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    regAddr = a;
    regRd = 1'b1;
    @(negedge sys_clk);
    regRd = 1'b0;
    @(negedge sys_clk);
    rdv = regRdData;
  endtask
  task automatic pwrOn(input chan_t m);
    @(negedge sys_clk);
    chOn = chOn | m;
    powerOnPulse = m;
    @(negedge sys_clk);
    powerOnPulse = '0;
  endtask
  // The wait is bounded, so a start that never comes shows up as wrong limits.
  task automatic measure(input logic [7:0] c);
    wr(8'h50, c);
    for (int i = 0; i < 400 && !(|acWindowDone); i++) @(negedge sys_clk);
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic t_regs();
    rd(8'h50);
    chk("ctrl reset", rdv, 8'h00);
    rd(8'h51);
    chk("power reset", rdv, 8'h00);
    wr(8'h50, 8'h0f);
    rd(8'h50);
    chk("ctrl rw", rdv, 8'h0f);
    wr(8'h51, 8'hff);
    rd(8'h51);
    chk("power ro", rdv, 8'h00);
    rd(8'h99);
    chk("unmapped", rdv, 8'h00);
    wr(8'h50, 8'h10);
    repeat (20) @(negedge sys_clk);
    chk("start while off", starts, 9'h000);
  endtask
  task automatic t_class();
    fourPairPort = 2'b01;
    allocClass = {CLS_1, CLS_1, CLS_2, CLS_4};
    prevClassIn[0] = CLS_5D;
    {semiAuto, detectEnable, classEnable, oneFinger} = {4{4'h3}};
    manualMode = 4'h2;
    pwrOn(4'h3);
    rd(8'h50);
    chk("req cleared", rdv, 8'h00);
    rd(8'h4c);
    chk("ch1 class", rdv, 8'h4d);
    rd(8'h4d);
    chk("manual class", rdv, 8'h00);
    chOn = 4'h1;
    manualMode = '0;
    classZero = 4'h2;
    prevClassIn[1] = 4'hc;
    repeat (2) @(negedge sys_clk);
    pwrOn(4'h2);
    rd(8'h4d);
    chk("class zero", rdv, 8'h30);
    rd(8'h4c);
    chk("dual own class", rdv, 8'h4d);
  endtask
  task automatic t_meas();
    for (int i = 0; i < 3; i++) begin
      powerSet[0] = pw[i];
      measure(8'h11);
      chk("pair limit", pairLimit[0], lim[i]);
      rd(8'h51);
      chk("power reg", rdv, {1'b0, pw[i]});
      rd(8'h50);
      chk("req self clear", rdv, 8'h01);
    end
  endtask
  task automatic t_four();
    {fourPairPort, singleSig} = 4'ha;
    allocClass[2] = CLS_6S;
    pairLimitWr = 4'h4;
    limitWrData = 9'h055;
    @(negedge sys_clk);
    pairLimitWr = '0;
    chOn = chOn | 4'h8;
    pwrOn(4'h4);
    rd(8'h4f);
    chk("partner class", rdv, 8'h90);
    classDone = 4'h4;
    @(negedge sys_clk);
    classDone = '0;
    chk("complete flag", classCompleteSet, 4'h4);
    @(negedge sys_clk);
    chk("flag pulse", classCompleteSet, 4'h0);
    wr(8'h50, 8'h40);
    repeat (40) @(negedge sys_clk);
    chk("lone request", starts, 9'h003);
    powerSet[2] = 7'h28;
    powerSet[3] = 7'h32;
    measure(8'hc4);
    chk("four limit", fourLimit[1], 9'h062);
    chk("pair kept", pairLimit[2], 9'h055);
  endtask

  initial begin
    repeat (4) @(negedge sys_clk);
    arst_n = 1'b1;
    t_regs();
    t_class();
    t_meas();
    t_four();
    conclude();
  end
  // The whole sequence needs about two hundred and fifty cycles.
  initial begin
    #(8 * 20000);
    n_mismatch++;
    conclude();
  end
endmodule // autoclass_power_limit_control_test
`default_nettype wire
